// file: tcic_pkg.sv
// Purpose: Shared constants, types and tables for capture conditioning
// Assumes: 32-bit register words, byte addresses on the register bus
// Notes:   Filter tables give sample counts and dead-time divisor powers
package tcic_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CAPVIEW = 8'h18;
  localparam logic [7:0] OFS_ENPOL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [31:0] RST_CAPVIEW = 32'h0000_0000;
  localparam logic [31:0] RST_ENPOL = 32'h0000_0000;
  localparam logic [31:0] MASK_CAPVIEW = 32'h0000_FFFF;
  localparam logic [31:0] MASK_ENPOL = 32'h0000_00BB;
  localparam logic [3:0] STRB_WORD = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CV_DIR_LSB = 0;
  localparam int CV_PSC_LSB = 2;
  localparam int CV_FLT_LSB = 4;
  localparam int CV_CH_STRIDE = 8;
  localparam int EP_EN_BIT = 0;
  localparam int EP_P_BIT = 1;
  localparam int EP_NP_BIT = 3;
  localparam int EP_CH_STRIDE = 4;
  localparam int NUM_CH = 2;
  localparam int PREDIV_W = 5;
  localparam int CAPCNT_W = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DIR_OUT = 2'h0,
    DIR_OWN = 2'h1,
    DIR_NEIGH = 2'h2,
    DIR_TRIG = 2'h3
  } tcic_dir_e;

  localparam logic [1:0] POL_RISE = 2'h0;
  localparam logic [1:0] POL_FALL = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h3;
  localparam logic [3:0] FLT_OFF = 4'h0;

  typedef struct packed {
    logic [3:0] filter_sel;
    logic [1:0] edge_divider;
    tcic_dir_e dir_sel;
    logic cc_enable;
    logic polarity;
    logic comp_polarity;
  } tcic_chcfg_s;

  // Consecutive samples needed per filter code
  function automatic logic [3:0] flt_count(input logic [3:0] sel);
    unique case (sel)
      4'h1: flt_count = 4'h2;
      4'h2: flt_count = 4'h4;
      4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hF: flt_count = 4'h8;
      4'h4, 4'h6, 4'h8, 4'hB, 4'hE: flt_count = 4'h6;
      4'hA, 4'hD: flt_count = 4'h5;
      default: flt_count = 4'h1;
    endcase
  endfunction

  // Power of two dividing the dead-time clock, zero for kernel clock
  function automatic logic [2:0] flt_div_log2(input logic [3:0] sel);
    unique case (sel)
      4'h4, 4'h5: flt_div_log2 = 3'h1;
      4'h6, 4'h7: flt_div_log2 = 3'h2;
      4'h8, 4'h9: flt_div_log2 = 3'h3;
      4'hA, 4'hB, 4'hC: flt_div_log2 = 3'h4;
      4'hD, 4'hE, 4'hF: flt_div_log2 = 3'h5;
      default: flt_div_log2 = 3'h0;
    endcase
  endfunction

endpackage

// file: tcic_filter.sv
// Purpose: Digital glitch filter for one capture channel input
// Assumes: Dead-time sample clock equals the kernel clock
// Notes:   Sample ticks come from a shared free-running predivider
`timescale 1ns/1ps
module tcic_filter import tcic_pkg::*; #(
  parameter int CNT_W = 4
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_in,
  input wire logic [3:0] i_sel,
  input wire logic [PREDIV_W-1:0] i_prediv,
  output logic o_level
);
  if (CNT_W < 4) begin : g_chk
    $error("tcic_filter: CNT_W too small");
  end

  logic level_r, level_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] need_m1;
  logic [PREDIV_W-1:0] mask;
  logic tick;

  // ****************************************
  // Sample and count
  // ****************************************
  always_comb begin
    need_m1 = CNT_W'(flt_count(i_sel) - 4'h1);
    mask = PREDIV_W'((6'h01 << flt_div_log2(i_sel)) - 6'h01);
    tick = ((i_prediv & mask) == mask);
    level_nxt = level_r;
    cnt_nxt = cnt_r;
    if (i_sel == FLT_OFF) begin
      level_nxt = i_in;
      cnt_nxt = '0;
    end else if (tick) begin
      if (i_in == level_r) begin
        cnt_nxt = '0;
      end else if (cnt_r >= need_m1) begin
        level_nxt = i_in;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      level_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_level = level_r;

  a_filter_bypass: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_sel == FLT_OFF) |=> (level_r == $past(i_in)))
    else $error("filter bypass did not follow input");

  a_filter_count_gate: assert property (@(posedge i_clock)
    disable iff (i_rst)
    ($past(i_sel) != FLT_OFF && level_r != $past(level_r))
    |-> ($past(cnt_r) >= $past(need_m1) && $past(tick)))
    else $error("filter level changed before count reached");

endmodule // tcic_filter

// file: tcic_edge_div.sv
// Purpose: Polarity edge select and capture prescaler for one channel
// Assumes: Input is the routed level, a filtered channel or the raw trigger
// Notes:   Capture pulse is one cycle, registered
`timescale 1ns/1ps
module tcic_edge_div import tcic_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire tcic_chcfg_s i_cfg,
  input wire logic i_level,
  output logic o_capture
);
  logic prev_r, prev_nxt;
  logic cap_r, cap_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] limit;
  logic rise, fall, hit;

  // ****************************************
  // Edge selection and counting
  // ****************************************
  always_comb begin
    rise = i_level & ~prev_r;
    fall = ~i_level & prev_r;
    unique case ({i_cfg.comp_polarity, i_cfg.polarity})
      POL_FALL: hit = fall;
      POL_BOTH: hit = rise | fall;
      default: hit = rise;
    endcase
    hit = hit && (i_cfg.dir_sel != DIR_OUT) && i_cfg.cc_enable;
    limit = 3'((4'h1 << i_cfg.edge_divider) - 4'h1);
    prev_nxt = i_level;
    cap_nxt = 1'b0;
    cnt_nxt = cnt_r;
    if (!i_cfg.cc_enable) begin
      cnt_nxt = '0;
    end else if (hit) begin
      if (cnt_r == limit) begin
        cap_nxt = 1'b1;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prev_r <= 1'b0;
      cap_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      cap_r <= cap_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_capture = cap_r;

  a_psc_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_cfg.cc_enable |=> (cnt_r == '0 && !cap_r))
    else $error("prescaler not cleared while disabled");

  a_psc_bypass: assert property (@(posedge i_clock) disable iff (i_rst)
    (hit && i_cfg.edge_divider == '0) |=> cap_r)
    else $error("bypassed prescaler missed an edge");

  a_cap_on_count: assert property (@(posedge i_clock) disable iff (i_rst)
    cap_r |-> ($past(hit) && $past(cnt_r) == $past(limit)))
    else $error("capture fired off the selected count");

endmodule // tcic_edge_div

// file: tcic_top.sv
// Purpose: Capture input conditioning for two timer channels
// Assumes: AXI4-Lite register access, inputs synchronous to i_clock
// Notes:   Dead-time sample clock is the kernel clock
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module tcic_top import tcic_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [ADDR_W-1:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  input wire logic i_chan0_input,
  input wire logic i_chan1_input,
  input wire logic i_internal_trigger_sel,
  output logic o_chan0_filtered_edge_a,
  output logic o_chan1_filtered_edge_to_a,
  output logic o_chan0_selected_input,
  output logic o_chan1_selected_input,
  output logic [NUM_CH-1:0] o_capture
);

  // ****************************************
  // Register bus state
  // ****************************************
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] cv_r, cv_nxt;
  logic [31:0] ep_r, ep_nxt;
  logic [31:0] merged;
  logic [31:0] status;
  logic [ADDR_W-1:0] wr_word, rd_word;
  logic do_wr;

  // ****************************************
  // Datapath state
  // ****************************************
  logic [PREDIV_W-1:0] prediv_r, prediv_nxt;
  logic [CAPCNT_W-1:0] capcnt_r [NUM_CH];
  logic [CAPCNT_W-1:0] capcnt_nxt [NUM_CH];
  tcic_chcfg_s cfg [NUM_CH];
  logic [NUM_CH-1:0] raw_in;
  logic [NUM_CH-1:0] filt;
  logic [NUM_CH-1:0] routed;
  logic [NUM_CH-1:0] cap;

  assign o_axi_awready = !aw_hold_r && !bvalid_r;
  assign o_axi_wready = !w_hold_r && !bvalid_r;
  assign o_axi_arready = !rvalid_r;
  assign o_axi_bvalid = bvalid_r;
  assign o_axi_bresp = bresp_r;
  assign o_axi_rvalid = rvalid_r;
  assign o_axi_rdata = rdata_r;
  assign o_axi_rresp = rresp_r;

  // ****************************************
  // Write path
  // ****************************************
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    cv_nxt = cv_r;
    ep_nxt = ep_r;
    merged = ep_r;
    wr_word = {awaddr_r[ADDR_W-1:2], 2'h0};
    do_wr = aw_hold_r && w_hold_r && !bvalid_r;
    if (i_axi_awvalid && o_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = i_axi_wdata;
      wstrb_nxt = i_axi_wstrb;
    end
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) begin
        merged[b*8 +: 8] = wdata_r[b*8 +: 8];
      end
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (wr_word == OFS_ENPOL) begin
        ep_nxt = merged & MASK_ENPOL;
      end else if (wr_word == OFS_CAPVIEW && wstrb_r == STRB_WORD) begin
        cv_nxt = wdata_r & MASK_CAPVIEW;
        for (int c = 0; c < NUM_CH; c++) begin
          if (ep_r[c*EP_CH_STRIDE + EP_EN_BIT]) begin
            cv_nxt[c*CV_CH_STRIDE + CV_DIR_LSB +: 2] =
              cv_r[c*CV_CH_STRIDE + CV_DIR_LSB +: 2];
          end
        end
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (bvalid_r && i_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      cv_r <= RST_CAPVIEW;
      ep_r <= RST_ENPOL;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      cv_r <= cv_nxt;
      ep_r <= ep_nxt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rd_word = {i_axi_araddr[ADDR_W-1:2], 2'h0};
    status = {capcnt_r[1], capcnt_r[0], 14'h0000, filt};
    if (i_axi_arvalid && o_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      if (rd_word == OFS_CAPVIEW) begin
        rdata_nxt = cv_r;
      end else if (rd_word == OFS_ENPOL) begin
        rdata_nxt = ep_r;
      end else if (rd_word == OFS_STATUS) begin
        rdata_nxt = status;
      end else begin
        rdata_nxt = '0;
        rresp_nxt = RESP_SLVERR;
      end
    end else if (rvalid_r && i_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ****************************************
  // Sample predivider and capture counters
  // ****************************************
  always_comb begin
    prediv_nxt = prediv_r + 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      capcnt_nxt[c] = capcnt_r[c] + CAPCNT_W'(cap[c]);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prediv_r <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        capcnt_r[c] <= '0;
      end
    end else begin
      prediv_r <= prediv_nxt;
      for (int c = 0; c < NUM_CH; c++) begin
        capcnt_r[c] <= capcnt_nxt[c];
      end
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  assign raw_in = {i_chan1_input, i_chan0_input};

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always_comb begin
      cfg[g].filter_sel = cv_r[g*CV_CH_STRIDE + CV_FLT_LSB +: 4];
      cfg[g].edge_divider = cv_r[g*CV_CH_STRIDE + CV_PSC_LSB +: 2];
      cfg[g].dir_sel = tcic_dir_e'(cv_r[g*CV_CH_STRIDE + CV_DIR_LSB +: 2]);
      cfg[g].cc_enable = ep_r[g*EP_CH_STRIDE + EP_EN_BIT];
      cfg[g].polarity = ep_r[g*EP_CH_STRIDE + EP_P_BIT];
      cfg[g].comp_polarity = ep_r[g*EP_CH_STRIDE + EP_NP_BIT];
      unique case (cfg[g].dir_sel)
        DIR_NEIGH: routed[g] = filt[NUM_CH-1-g];
        DIR_TRIG: routed[g] = i_internal_trigger_sel;
        DIR_OWN: routed[g] = filt[g];
        DIR_OUT: routed[g] = 1'b0;
      endcase
    end

    tcic_filter #(.CNT_W(4)) u_filter (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_in(raw_in[g]),
      .i_sel(cfg[g].filter_sel),
      .i_prediv(prediv_r),
      .o_level(filt[g])
    );

    tcic_edge_div u_edge (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_cfg(cfg[g]),
      .i_level(routed[g]),
      .o_capture(cap[g])
    );
  end

  assign o_chan0_filtered_edge_a = filt[0];
  assign o_chan1_filtered_edge_to_a = filt[1];
  assign o_chan0_selected_input = routed[0];
  assign o_chan1_selected_input = routed[1];
  assign o_capture = cap;

  // ****************************************
  // Checks
  // ****************************************
  a_enpol_reserved: assert property (@(posedge i_clock) disable iff (i_rst)
    (ep_r & ~MASK_ENPOL) == '0)
    else $error("reserved enable bits set");

  a_dir_locked: assert property (@(posedge i_clock) disable iff (i_rst)
    $past(ep_r[EP_EN_BIT]) |->
    cv_r[CV_DIR_LSB +: 2] == $past(cv_r[CV_DIR_LSB +: 2]))
    else $error("mode changed while channel enabled");

  a_route_neigh: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg[0].dir_sel == DIR_NEIGH) |->
    (o_chan0_selected_input == filt[1]))
    else $error("neighbour routing wrong");

  a_bad_addr_resp: assert property (@(posedge i_clock) disable iff (i_rst)
    (do_wr && wr_word != OFS_ENPOL && wr_word != OFS_CAPVIEW)
    |=> (bvalid_r && bresp_r == RESP_SLVERR && $stable(ep_r)))
    else $error("unmapped write not refused");

endmodule // tcic_top

// file: tcic_cap_src.sv
// Purpose: Far-side source of the capture and trigger inputs
// Assumes: Levels change just after a rising clock edge
// Notes:   The bench steers it through the drive task
`timescale 1ns/1ps
module tcic_cap_src (
  input wire logic i_clock,
  output logic o_ch0,
  output logic o_ch1,
  output logic o_trig
);
  // ****************************************
  // Input levels
  // ****************************************
  logic [2:0] lv_r = 3'h0;
  assign o_ch0 = lv_r[0];
  assign o_ch1 = lv_r[1];
  assign o_trig = lv_r[2];

  // Set the masked lines to v and hold them for n cycles
  task automatic drive(input logic [2:0] m, input logic v, input int n);
    @(posedge i_clock);
    lv_r <= v ? (lv_r | m) : (lv_r & ~m);
    repeat (n - 1) @(posedge i_clock);
  endtask
endmodule // tcic_cap_src

// file: tcic_top_test.sv
// Purpose: Self-checking bench for capture input conditioning
// Assumes: AXI4-Lite master tasks, far-side input source model
// Notes:   Dead-time clock equals the kernel clock
`timescale 1ns/1ps
module tcic_top_test import tcic_pkg::*;;
  // ****************************************
  // Signals and design
  // ****************************************
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'h0;
  logic awr, wr_rdy, bv, arr, rv, ch0, ch1, trg, f0, f1, s0, s1;
  logic [1:0] br, rr, cap;
  logic [31:0] rd;
  int failures = 0, n_compared = 0, cap0 = 0, cap1 = 0;
  int hi0 = 0, hi1 = 0, c0, c1, h;
  int fcnt[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int fdiv[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
  logic [31:0] ep_t[4] = '{32'h11, 32'h33, 32'hBB, 32'h99};
  int up_t[4] = '{1, 0, 1, 1};
  int dn_t[4] = '{1, 1, 2, 1};

  always #2.5 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cap0 <= cap0 + int'(cap[0] === 1'b1);
    cap1 <= cap1 + int'(cap[1] === 1'b1);
    hi0 <= hi0 + int'(f0 === 1'b1);
    hi1 <= hi1 + int'(f1 === 1'b1);
  end

  tcic_top tcic_top_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa),
    .i_axi_wvalid(wv), .o_axi_wready(wr_rdy), .i_axi_wdata(wd),
    .i_axi_wstrb(ws), .o_axi_bvalid(bv), .i_axi_bready(brdy),
    .o_axi_bresp(br), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .i_axi_araddr(ara), .o_axi_rvalid(rv), .i_axi_rready(rrdy),
    .o_axi_rdata(rd), .o_axi_rresp(rr), .i_chan0_input(ch0),
    .i_chan1_input(ch1), .i_internal_trigger_sel(trg),
    .o_chan0_filtered_edge_a(f0), .o_chan1_filtered_edge_to_a(f1),
    .o_chan0_selected_input(s0), .o_chan1_selected_input(s1),
    .o_capture(cap));

  tcic_cap_src tcic_cap_src_inst (.i_clock(i_clock), .o_ch0(ch0),
    .o_ch1(ch1), .o_trig(trg));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] e);
    @(posedge i_clock);
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    awa <= a;
    wd <= d;
    ws <= s;
    do begin
      @(posedge i_clock);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    brdy <= 1'b0;
    check(br, e);
  endtask

  task automatic rck(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge i_clock);
    arv <= 1'b1;
    ara <= a;
    rrdy <= 1'b1;
    do begin
      @(posedge i_clock);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rrdy <= 1'b0;
    check(rd, e);
    check(rr, er);
  endtask

  task automatic cfg(input logic [31:0] cv, input logic [31:0] ep);
    wr(OFS_ENPOL, 32'h0, STRB_WORD, RESP_OKAY);
    wr(OFS_CAPVIEW, cv, STRB_WORD, RESP_OKAY);
    wr(OFS_ENPOL, ep, STRB_WORD, RESP_OKAY);
  endtask

  task automatic dv(input logic [2:0] m, input logic v, input int n);
    tcic_cap_src_inst.drive(m, v, n);
  endtask

  task automatic pulse;
    dv(3'h3, 1'b1, 3);
    dv(3'h3, 1'b0, 3);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check({26'h0, cap, f0, f1, s0, s1}, 32'h0);
    rck(OFS_CAPVIEW, 32'h0, RESP_OKAY);
    rck(OFS_ENPOL, 32'h0, RESP_OKAY);
    rck(OFS_STATUS, 32'h0, RESP_OKAY);
    $display("done reset");
  endtask

  task automatic t_regs;
    wr(OFS_ENPOL, 32'hBB, STRB_WORD, RESP_OKAY);
    rck(OFS_ENPOL, 32'hBB, RESP_OKAY);
    wr(OFS_ENPOL, 32'h11, 4'h3, RESP_OKAY);
    rck(OFS_ENPOL, 32'h11, RESP_OKAY);
    rck(8'h40, 32'h0, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0, STRB_WORD, RESP_SLVERR);
    rck(OFS_ENPOL, 32'h11, RESP_OKAY);
    $display("done regs");
  endtask

  task automatic t_lock;
    cfg(32'h0001, 32'h01);
    wr(OFS_CAPVIEW, 32'h0252, STRB_WORD, RESP_OKAY);
    rck(OFS_CAPVIEW, 32'h0251, RESP_OKAY);
    wr(OFS_ENPOL, 32'h10, STRB_WORD, RESP_OKAY);
    wr(OFS_CAPVIEW, 32'h0101, STRB_WORD, RESP_OKAY);
    rck(OFS_CAPVIEW, 32'h0201, RESP_OKAY);
    $display("done lock");
  endtask

  task automatic t_route;
    for (int m = 0; m < 4; m++) begin
      cfg(32'h0100 | m, 32'h0);
      dv(3'h6, 1'b0, 1);
      dv(3'h1, 1'b1, 4);
      #1;
      check(s0, m == 1);
      dv(3'h1, 1'b0, 1);
      dv(3'h6, 1'b1, 4);
      #1;
      check(s0, m >= 2);
      check(s1, 1'b1);
      dv(3'h6, 1'b0, 4);
    end
    $display("done route");
  endtask

  task automatic t_walk;
    int n;
    cfg(32'h0001, 32'h01);
    dv(3'h1, 1'b1, 1);
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (f0 !== 1'b1 && n < 4);
    check(n <= 2, 1'b1);
    check(cap[0], 1'b0);
    @(posedge i_clock);
    #1;
    check(cap[0], 1'b1);
    @(posedge i_clock);
    #1;
    check(cap[0], 1'b0);
    dv(3'h1, 1'b0, 4);
    $display("done walk");
  endtask

  task automatic t_filter;
    for (int c = 1; c < 16; c++) begin
      cfg({16'h0, c[3:0], 4'h1, c[3:0], 4'h1}, 32'h11);
      h = hi0 + hi1;
      dv(3'h3, 1'b1, (fcnt[c] - 1) * fdiv[c]);
      dv(3'h3, 1'b0, (fcnt[c] + 2) * fdiv[c] + 3);
      check(hi0 + hi1 - h, 0);
      dv(3'h3, 1'b1, (fcnt[c] + 2) * fdiv[c] + 3);
      #1;
      check({f1, f0}, 2'h3);
      dv(3'h3, 1'b0, (fcnt[c] + 2) * fdiv[c] + 3);
      #1;
      check({f1, f0}, 2'h0);
    end
    $display("done filter");
  endtask

  task automatic t_psc;
    for (int p = 0; p < 4; p++) begin
      cfg({16'h0, 4'h0, p[1:0], 2'h1, 4'h0, p[1:0], 2'h1}, 32'h11);
      c0 = cap0;
      c1 = cap1;
      repeat (9) pulse;
      check(cap0 - c0, 9 >> p);
      check(cap1 - c1, 9 >> p);
    end
    $display("done prescale");
  endtask

  task automatic t_clear;
    cfg(32'h0505, 32'h11);
    c0 = cap0;
    c1 = cap1;
    pulse;
    wr(OFS_ENPOL, 32'h0, STRB_WORD, RESP_OKAY);
    wr(OFS_ENPOL, 32'h11, STRB_WORD, RESP_OKAY);
    pulse;
    check(cap0 - c0, 0);
    check(cap1 - c1, 0);
    pulse;
    check(cap0 - c0, 1);
    check(cap1 - c1, 1);
    $display("done clear");
  endtask

  task automatic t_pol;
    for (int k = 0; k < 4; k++) begin
      cfg(32'h0101, ep_t[k]);
      c0 = cap0;
      c1 = cap1;
      dv(3'h3, 1'b1, 6);
      check(cap0 - c0, up_t[k]);
      check(cap1 - c1, up_t[k]);
      dv(3'h3, 1'b0, 6);
      check(cap0 - c0, dn_t[k]);
      check(cap1 - c1, dn_t[k]);
    end
    $display("done polarity");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset;
    t_regs;
    t_lock;
    t_route;
    t_walk;
    t_filter;
    t_psc;
    t_clear;
    t_pol;
    stop_test;
  end

  initial begin
    repeat (40000) @(posedge i_clock);
    failures++;
    stop_test;
  end
endmodule // tcic_top_test
